// ==== logic/irq_pend_pkg.sv ====
// constants for the interrupt pending control block
package irq_pend_pkg;
    localparam int NUM_IRQ = 32;
    localparam int ADDR_W = 4;
    // register byte offsets
    localparam logic [3:0] OFS_PEND_SET = 4'h0;
    localparam logic [3:0] OFS_PEND_CLEAR = 4'h4;
    localparam logic [3:0] OFS_ENABLE_SET = 4'h8;
    localparam logic [3:0] OFS_ENABLE_CLEAR = 4'hc;
    // reset values
    localparam logic [31:0] RST_PEND = 32'h0000_0000;
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
endpackage

// ==== logic/interrupt_pending_control.sv ====
// pending state for 32 interrupt sources with a wishbone register slave
// Operation
// - writing one to a set-pending bit makes that interrupt pending
// - bits 31 to 0 map directly onto interrupt numbers 31 to 0
// - set-pending has no effect when already pending or disabled
// - either pending register reads one for pending, zero otherwise
// - writing one to a clear-pending bit removes pending state
// - clear-pending has no effect on an interrupt being serviced
// - set and clear views share one pending state
// - of set and clear on one interrupt, the later request wins
// - external line with wake release and port input both off reads high
// - writing one to set-enable enables the interrupt, gating set-pending
`timescale 1ns/1ps
module interrupt_pending_control #(
    parameter int NUM_EXT = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt request lines, asynchronous
    input wire logic [31:0] irqLine,
    // external pin controls for the low NUM_EXT sources
    input wire logic [NUM_EXT-1:0] wake_release_enable,
    input wire logic [NUM_EXT-1:0] port_input_enable,
    // core side
    input wire logic [31:0] activeIrq,
    output logic [31:0] pendingOut,
    output logic irqReq
);
    logic rstSync1_ff;
    logic rstSync2_ff;
    logic [31:0] lineMeta_ff;
    logic [31:0] lineSync_ff;
    logic [31:0] pend_ff;
    logic [31:0] nxt_pend;
    logic [31:0] enable_ff;
    logic [31:0] effLine;
    logic [31:0] wdat;
    logic [31:0] pend_set_bits;
    logic [31:0] pend_clear_bits;
    logic [31:0] enable_set_bits;
    logic [31:0] enable_clear_bits;
    logic wbReq;
    logic wrStb;

    // merge byte enables into write data mask
    function automatic logic [31:0] laneMask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end
        else
        begin
            rstSync1_ff <= 1'b1;
            rstSync2_ff <= rstSync1_ff;
        end
    end

    // request line synchroniser
    always_ff @(posedge clk or negedge rstSync2_ff)
    begin
        if (!rstSync2_ff)
        begin
            lineMeta_ff <= 32'h0000_0000;
            lineSync_ff <= 32'h0000_0000;
        end
        else
        begin
            lineMeta_ff <= irqLine;
            lineSync_ff <= lineMeta_ff;
        end
    end

    // external lines forced high when both controls are off
    always_comb
    begin
        effLine = lineSync_ff;
        for (int i = 0; i < NUM_EXT; i++)
        begin
            if (!wake_release_enable[i] && !port_input_enable[i])
            begin
                effLine[i] = 1'b1;
            end
        end
    end

    // bus write decode
    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrStb = wbReq && wb_we_i;
    assign wdat = wb_dat_i & laneMask(wb_sel_i);
    assign pend_set_bits = (wrStb && wb_adr_i == irq_pend_pkg::OFS_PEND_SET) ? wdat : '0;
    assign pend_clear_bits = (wrStb && wb_adr_i == irq_pend_pkg::OFS_PEND_CLEAR) ? wdat : '0;
    assign enable_set_bits = (wrStb && wb_adr_i == irq_pend_pkg::OFS_ENABLE_SET) ? wdat : '0;
    assign enable_clear_bits =
        (wrStb && wb_adr_i == irq_pend_pkg::OFS_ENABLE_CLEAR) ? wdat : '0;

    // enable state
    always_ff @(posedge clk or negedge rstSync2_ff)
    begin
        if (!rstSync2_ff)
        begin
            enable_ff <= irq_pend_pkg::RST_ENABLE;
        end
        else
        begin
            enable_ff <= (enable_ff | enable_set_bits) & ~enable_clear_bits;
        end
    end

    // next pending state
    always_comb
    begin
        nxt_pend = pend_ff;
        // hardware lines pend enabled sources
        nxt_pend = nxt_pend | (effLine & enable_ff & ~activeIrq);
        nxt_pend = nxt_pend | (pend_set_bits & enable_ff);
        nxt_pend = nxt_pend & ~(pend_clear_bits & ~activeIrq);
        // serviced interrupts leave pending
        nxt_pend = nxt_pend & ~activeIrq;
    end

    // pending state; one write per bus cycle so latest write wins
    always_ff @(posedge clk or negedge rstSync2_ff)
    begin
        if (!rstSync2_ff)
        begin
            pend_ff <= irq_pend_pkg::RST_PEND;
        end
        else
        begin
            pend_ff <= nxt_pend;
        end
    end

    // bus answer, one cycle after request
    always_ff @(posedge clk or negedge rstSync2_ff)
    begin
        if (!rstSync2_ff)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wbReq;
            wb_dat_o <= 32'h0000_0000;
            if (wbReq && !wb_we_i)
            begin
                case (wb_adr_i)
                    irq_pend_pkg::OFS_PEND_SET: wb_dat_o <= pend_ff;
                    irq_pend_pkg::OFS_PEND_CLEAR: wb_dat_o <= pend_ff;
                    irq_pend_pkg::OFS_ENABLE_SET: wb_dat_o <= enable_ff;
                    irq_pend_pkg::OFS_ENABLE_CLEAR: wb_dat_o <= enable_ff;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // core outputs
    always_ff @(posedge clk or negedge rstSync2_ff)
    begin
        if (!rstSync2_ff)
        begin
            pendingOut <= 32'h0000_0000;
            irqReq <= 1'b0;
        end
        else
        begin
            pendingOut <= nxt_pend;
            irqReq <= |nxt_pend;
        end
    end

    // checks
    property p_set_pends;
        @(posedge clk) disable iff (!rstSync2_ff)
        (wrStb && wb_adr_i == irq_pend_pkg::OFS_PEND_SET && wb_sel_i[0] && wb_dat_i[0]
            && enable_ff[0] && !activeIrq[0]) |=> pend_ff[0];
    endproperty
    a_set_pends: assert property (p_set_pends) else $error("set did not pend");
    property p_disabled_no_set;
        @(posedge clk) disable iff (!rstSync2_ff)
        (!pend_ff[1] && !enable_ff[1]) |=> !pend_ff[1];
    endproperty
    a_disabled_no_set: assert property (p_disabled_no_set) else $error("disabled pended");
    property p_clear;
        @(posedge clk) disable iff (!rstSync2_ff)
        (wrStb && wb_adr_i == irq_pend_pkg::OFS_PEND_CLEAR && wb_sel_i[0] && wb_dat_i[0]
            && !effLine[0]) |=> !pend_ff[0];
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_zero_write_keeps;
        @(posedge clk) disable iff (!rstSync2_ff)
        (pend_ff[2] && !activeIrq[2] && !pend_clear_bits[2]) |=> pend_ff[2];
    endproperty
    a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("bit lost");
    property p_read_pend;
        @(posedge clk) disable iff (!rstSync2_ff)
        (wbReq && !wb_we_i && wb_adr_i == irq_pend_pkg::OFS_PEND_CLEAR)
            |=> wb_ack_o && wb_dat_o == $past(pend_ff);
    endproperty
    a_read_pend: assert property (p_read_pend) else $error("bad pending read");
    property p_forced_line;
        @(posedge clk) disable iff (!rstSync2_ff)
        (!wake_release_enable[0] && !port_input_enable[0]) |-> effLine[0];
    endproperty
    a_forced_line: assert property (p_forced_line) else $error("line not forced");
    property p_enable_set;
        @(posedge clk) disable iff (!rstSync2_ff)
        (enable_set_bits[3] && !enable_clear_bits[3]) |=> enable_ff[3];
    endproperty
    a_enable_set: assert property (p_enable_set) else $error("enable not set");
    property p_ack_drop;
        @(posedge clk) disable iff (!rstSync2_ff)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack held");
    property p_out_follow;
        @(posedge clk) disable iff (!rstSync2_ff)
        1'b1 |=> pendingOut == pend_ff;
    endproperty
    a_out_follow: assert property (p_out_follow) else $error("output mismatch");
    // core request tracks the shared pending state
    property p_irq_level;
        @(posedge clk) disable iff (!rstSync2_ff)
        1'b1 |=> irqReq == (|pend_ff);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("request level wrong");
    // every set bit of an enabled, unserviced interrupt lands on its own interrupt
    property p_map_bits;
        @(posedge clk) disable iff (!rstSync2_ff)
        (|(pend_set_bits & enable_ff & ~activeIrq))
            |=> (pend_ff & $past(pend_set_bits & enable_ff & ~activeIrq))
                == $past(pend_set_bits & enable_ff & ~activeIrq);
    endproperty
    a_map_bits: assert property (p_map_bits) else $error("set bit mapped wrong");
    // clear of a serviced interrupt leaves it out of pending
    property p_clear_serviced;
        @(posedge clk) disable iff (!rstSync2_ff)
        (|(pend_clear_bits & activeIrq))
            |=> (pend_ff & $past(pend_clear_bits & activeIrq)) == 32'h0000_0000;
    endproperty
    a_clear_serviced: assert property (p_clear_serviced) else $error("serviced pended");
    // a masked byte lane writes nothing
    property p_lane_off;
        @(posedge clk) disable iff (!rstSync2_ff)
        (wrStb && wb_adr_i == irq_pend_pkg::OFS_PEND_SET && !wb_sel_i[0] && !pend_ff[0]
            && !effLine[0]) |=> !pend_ff[0];
    endproperty
    a_lane_off: assert property (p_lane_off) else $error("masked lane pended");
    // software clear beats a line in the same cycle
    property p_clear_beats_line;
        @(posedge clk) disable iff (!rstSync2_ff)
        (pend_clear_bits[9] && effLine[9] && !activeIrq[9]) |=> !pend_ff[9];
    endproperty
    a_clear_beats_line: assert property (p_clear_beats_line) else $error("line beat clear");
    // a present line pends an enabled source
    property p_forced_pends;
        @(posedge clk) disable iff (!rstSync2_ff)
        (effLine[1] && enable_ff[1] && !activeIrq[1] && !pend_clear_bits[1]) |=> pend_ff[1];
    endproperty
    a_forced_pends: assert property (p_forced_pends) else $error("line not pended");
    // read data only in the answer cycle
    property p_dat_idle;
        @(posedge clk) disable iff (!rstSync2_ff)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("stray read data");
    // main scenarios
    c_write_set: cover property (@(posedge clk) wrStb && wb_adr_i == irq_pend_pkg::OFS_PEND_SET);
    c_write_clr: cover property (@(posedge clk) |pend_clear_bits);
    c_irq: cover property (@(posedge clk) $rose(irqReq));
    c_clear_serviced: cover property (@(posedge clk) |(pend_clear_bits & activeIrq));
    c_forced: cover property (@(posedge clk) effLine[1] && !lineSync_ff[1]);
endmodule

// ==== bench/irq_src_model.sv ====
// behavioural request lines and core service levels
`timescale 1ns/1ps
module irq_src_model (
    // clock
    input wire logic clk,
    // wanted levels from the bench
    input wire logic [31:0] lineReq,
    input wire logic [31:0] actReq,
    input wire logic slow,
    // levels toward the block
    output logic [31:0] irqLine,
    output logic [31:0] activeIrq
);
    logic [31:0] lineDly_ff;
    logic [31:0] actDly_ff;
    // levels move only after an edge, one stage later when slow
    always_ff @(posedge clk)
    begin
        lineDly_ff <= lineReq;
        actDly_ff <= actReq;
        irqLine <= slow ? lineDly_ff : lineReq;
        activeIrq <= slow ? actDly_ff : actReq;
    end
endmodule

// ==== bench/interrupt_pending_control_tb.sv ====
// self-checking bench for the interrupt pending control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module interrupt_pending_control_tb;
    localparam logic [3:0] PS = irq_pend_pkg::OFS_PEND_SET;
    localparam logic [3:0] PC = irq_pend_pkg::OFS_PEND_CLEAR;
    localparam logic [3:0] ES = irq_pend_pkg::OFS_ENABLE_SET;
    localparam logic [3:0] EC = irq_pend_pkg::OFS_ENABLE_CLEAR;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic slow = 1'b0;
    logic ack;
    logic irqReq;
    logic [3:0] adr = 4'h0;
    logic [3:0] wre = 4'h0;
    logic [3:0] pie = 4'hf;
    logic [3:0] sel = 4'hf;
    logic [3:0] ls;
    logic [31:0] wdat = 32'h0;
    logic [31:0] lineReq = 32'h0;
    logic [31:0] actReq = 32'h0;
    logic [31:0] rdat, irqLine, activeIrq, pendingOut, r, d, m;
    logic [31:0] seed = 32'hd52f7638;
    logic [31:0] expPend = 32'h0;
    logic [31:0] expEn = 32'h0;
    int mismatches = 0;
    int n_compared = 0;
    int i;
    // block and far side model
    interrupt_pending_control #(.NUM_EXT(4)) interrupt_pending_control_i (.clk(clk),
        .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irqLine(irqLine), .wake_release_enable(wre), .port_input_enable(pie),
        .activeIrq(activeIrq), .pendingOut(pendingOut), .irqReq(irqReq));
    irq_src_model irq_src_model_i (.clk(clk), .lineReq(lineReq), .actReq(actReq),
        .slow(slow), .irqLine(irqLine), .activeIrq(activeIrq));
    // free running clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] fSet(logic [31:0] p, logic [31:0] e, logic [31:0] v);
        return p | (v & e);
    endfunction
    // byte lanes that a write may change
    function automatic logic [31:0] lanes(logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wbx(input logic w, input logic [3:0] a, input logic [31:0] v,
        input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, v};
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            mismatches++;
            summarize();
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic [31:0] q;
        wbx(1'b1, a, v, 4'hf, q);
    endtask
    task automatic wrm(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
        logic [31:0] q;
        wbx(1'b1, a, v, s, q);
    endtask
    task automatic ck(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        wbx(1'b0, a, 32'h0, 4'hf, q);
        `CHK(q, e)
    endtask
    task automatic settle(input string s, input int n);
        repeat (n) @(posedge clk);
        $display("test %s done", s);
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        wr(EC, 32'hffffffff);
        wr(PC, 32'hffffffff);
        ck(PS, 32'h0);
        wr(ES, 32'hffffffff);
        for (i = 0; i < 32; i++)
        begin
            wr(PS, 32'h1 << i);
            ck(PS, (32'h2 << i) - 32'h1);
        end
        wr(PC, 32'h0);
        ck(PC, 32'hffffffff);
        wr(PC, 32'hffffffff);
        wr(EC, 32'h0000ff00);
        wr(PS, 32'hffffffff);
        ck(PS, 32'hffff00ff);
        wr(PC, 32'hffffffff);
        wr(PS, 32'h1);
        wr(PC, 32'h1);
        wr(PC, 32'h2);
        wr(PS, 32'h2);
        ck(PC, 32'h2);
        wr(4'h2, 32'hffffffff);
        ck(PS, 32'h2);
        ck(4'h2, 32'h0);
        // only the third byte lane is written
        wrm(PS, 32'hffffffff, 4'h4);
        ck(PS, 32'h00ff0002);
        settle("corners", 1);
        wr(ES, 32'hffffffff);
        wr(PC, 32'hffffffff);
        slow <= 1'b1;
        lineReq <= 32'h200;
        settle("line", 8);
        // clear while the line is still high, line pends again
        wr(PC, 32'h200);
        lineReq <= 32'h0;
        ck(PS, 32'h200);
        `CHK(pendingOut, 32'h200)
        `CHK(irqReq, 1'b1)
        actReq <= 32'h200;
        settle("service", 8);
        wr(PC, 32'h200);
        ck(PS, 32'h0);
        actReq <= 32'h0;
        pie <= 4'hd;
        settle("forced", 8);
        ck(PS, 32'h2);
        // port input back on keeps the stale request pending until software clears it
        pie <= 4'hf;
        wre <= 4'h2;
        settle("release", 8);
        pie <= 4'hd;
        wr(PC, 32'hffffffff);
        ck(PS, 32'h0);
        pie <= 4'hf;
        wr(EC, 32'hffffffff);
        for (i = 0; i < 40; i++)
        begin
            r = xs();
            d = xs();
            ls = r[7:4];
            m = d & lanes(ls);
            if (r[1:0] == 2'h0)
                expPend = fSet(expPend, expEn, m);
            else if (r[1:0] == 2'h1)
                expPend = expPend & ~m;
            else if (r[1:0] == 2'h2)
                expEn = expEn | m;
            else
                expEn = expEn & ~m;
            wrm({r[1:0], 2'b00}, d, ls);
            ck(PS, expPend);
            ck(PC, expPend);
            ck(EC, expEn);
            `CHK(pendingOut, expPend)
            `CHK(irqReq, |expPend)
        end
        settle("random", 1);
        // reset in mid-run, pending cleared by software before use
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        ck(ES, 32'h0);
        wr(PC, 32'hffffffff);
        ck(PS, 32'h0);
        settle("reset", 1);
        summarize();
    end
endmodule
